/* core/ssrs_pkg.sv */
// Purpose: constants for the supply reset supervisor
// Assumes: 40 MHz core clock
// Notes: power-on delay is a parameter default of the top module
package ssrs_pkg;
   localparam int unsigned SSRS_CLK_HZ = 40000000;
   localparam int unsigned SSRS_POR_US = 100;
   localparam int unsigned SSRS_POR_CYC =
      (SSRS_POR_US * (SSRS_CLK_HZ / 1000000) < 1) ? 1 :
      SSRS_POR_US * (SSRS_CLK_HZ / 1000000);
   localparam int unsigned SSRS_CNT_W = 24;
   localparam int unsigned SSRS_NCH = 3;
   localparam int unsigned SSRS_WD_LIMIT = 64;
   localparam int unsigned SSRS_WD_W = 8;
   localparam logic [SSRS_CNT_W-1:0] SSRS_CNT_RST = 24'h000000;
   localparam logic [SSRS_WD_W-1:0] SSRS_WD_RST = 8'h00;
   typedef enum logic [1:0] {
      SSRS_HOLD = 2'b00,
      SSRS_WAIT = 2'b01,
      SSRS_RUN = 2'b11
   } ssrs_state_type;
endpackage

/* core/ssrs_sync.sv */
// Purpose: two-flop synchroniser for a bus of asynchronous levels
// Assumes: inputs are quasi-static comparator levels
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module ssrs_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Data
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end
   assign o_q = sync_q;
endmodule // ssrs_sync

/* core/ssrs_top.sv */
// Purpose: supply supervision, power-on reset sequencing, reset flag
// Assumes: comparator and clock-detect inputs are asynchronous pins
// Notes: o_spi_ready tells the serial port it may accept traffic
`timescale 1ns/1ps
module ssrs_top
   import ssrs_pkg::*;
#(
   parameter int unsigned POR_CYCLES = SSRS_POR_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Supply comparators, high means below threshold
   input wire logic i_digital_supply_low,
   input wire logic i_analog_supply_low,
   input wire logic i_reference_supply_low,
   input wire logic [SSRS_NCH-1:0] i_channel_load_supply_low,
   // Input clock watchdog
   input wire logic i_wd_enable,
   input wire logic i_clk_pulse,
   // Status_word_a status word access strobe from serial port logic
   input wire logic i_status_word_a_access,
   // Outputs
   output logic o_logic_reset,
   output logic o_spi_ready,
   output logic o_reset_flag,
   output logic [SSRS_NCH-1:0] o_load_supply_undervoltage_flag,
   output logic [SSRS_NCH-1:0] o_stage_enable
);
   localparam int unsigned NIN = 5 + SSRS_NCH;
   logic [NIN-1:0] raw;
   logic [NIN-1:0] syn;
   logic sup_low;
   logic wd_en;
   logic pulse_s;
   logic [SSRS_NCH-1:0] lsup_low;

   // Main supplies cross as good levels, so the sync reset value reads as low
   assign raw = {i_clk_pulse, i_wd_enable, i_channel_load_supply_low,
      ~i_reference_supply_low, ~i_analog_supply_low, ~i_digital_supply_low};

   ssrs_sync #(.W(NIN)) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(raw),
      .o_q(syn)
   );

   assign sup_low = ~&syn[2:0];
   assign lsup_low = syn[3 +: SSRS_NCH];
   assign wd_en = syn[NIN-2];
   assign pulse_s = syn[NIN-1];

   // Watchdog: counts cycles since last edge of the divided input clock
   logic pulse_prev_q, pulse_prev_d;
   logic [SSRS_WD_W-1:0] wd_cnt_q, wd_cnt_d;
   logic clk_missing;

   always_comb begin
      pulse_prev_d = pulse_s;
      if (pulse_s != pulse_prev_q) begin
         wd_cnt_d = SSRS_WD_RST;
      end else if (wd_cnt_q != SSRS_WD_W'(SSRS_WD_LIMIT)) begin
         wd_cnt_d = wd_cnt_q + 1'b1;
      end else begin
         wd_cnt_d = wd_cnt_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pulse_prev_q <= 1'b0;
         wd_cnt_q <= SSRS_WD_RST;
      end else begin
         pulse_prev_q <= pulse_prev_d;
         wd_cnt_q <= wd_cnt_d;
      end
   end

   // Saturated count means no edge seen for too long
   assign clk_missing = wd_en &&
      (wd_cnt_q == SSRS_WD_W'(SSRS_WD_LIMIT));

   logic hold_cond;
   assign hold_cond = sup_low || clk_missing;

   // Sequencer
   ssrs_state_type st_q, st_d;
   logic [SSRS_CNT_W-1:0] cnt_q, cnt_d;
   logic rst_out_q, rst_out_d;
   logic rdy_q, rdy_d;
   logic flag_q, flag_d;
   logic [SSRS_NCH-1:0] uv_q, uv_d;
   logic [SSRS_NCH-1:0] en_q, en_d;
   logic leaving;

   // A status_word_a access counts only while the serial port is open
   function automatic logic acc_ok(input logic acc, input logic rdy);
      return acc && rdy;
   endfunction

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      leaving = 1'b0;
      unique case (st_q)
         SSRS_HOLD: begin
            cnt_d = SSRS_CNT_RST;
            if (!hold_cond) begin
               st_d = SSRS_WAIT;
            end
         end
         SSRS_WAIT: begin
            if (hold_cond) begin
               st_d = SSRS_HOLD;
               cnt_d = SSRS_CNT_RST;
            end else if (cnt_q == SSRS_CNT_W'(POR_CYCLES - 1)) begin
               st_d = SSRS_RUN;
               leaving = 1'b1;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         SSRS_RUN: begin
            if (hold_cond) begin
               st_d = SSRS_HOLD;
            end
         end
         default: begin
            st_d = SSRS_HOLD;
         end
      endcase
      rst_out_d = (st_d != SSRS_RUN);
      rdy_d = (st_d == SSRS_RUN);
      // Set wins over an access in the same cycle
      if (leaving) begin
         flag_d = 1'b1;
      end else if (acc_ok(i_status_word_a_access, rdy_q)) begin
         flag_d = 1'b0;
      end else begin
         flag_d = flag_q;
      end
      // Undervoltage flags are logic state, so they clear while held in reset
      uv_d = (st_d == SSRS_RUN) ? uv_q : '0;
      for (int i = 0; i < SSRS_NCH; i++) begin
         if (lsup_low[i] && st_d == SSRS_RUN) begin
            uv_d[i] = 1'b1;
         end else if (acc_ok(i_status_word_a_access, rdy_q)) begin
            uv_d[i] = 1'b0;
         end
      end
      en_d = (st_d == SSRS_RUN) ? ~lsup_low : '0;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= SSRS_HOLD;
         cnt_q <= SSRS_CNT_RST;
         rst_out_q <= 1'b1;
         rdy_q <= 1'b0;
         flag_q <= 1'b0;
         uv_q <= '0;
         en_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rst_out_q <= rst_out_d;
         rdy_q <= rdy_d;
         flag_q <= flag_d;
         uv_q <= uv_d;
         en_q <= en_d;
      end
   end

   assign o_logic_reset = rst_out_q;
   assign o_spi_ready = rdy_q;
   assign o_reset_flag = flag_q;
   assign o_load_supply_undervoltage_flag = uv_q;
   assign o_stage_enable = en_q;

   // Independent count of clean cycles, read by the checks only
   logic [SSRS_CNT_W-1:0] ok_q, ok_d;

   always_comb begin
      if (hold_cond) begin
         ok_d = SSRS_CNT_RST;
      end else if (ok_q != '1) begin
         ok_d = ok_q + 1'b1;
      end else begin
         ok_d = ok_q;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ok_q <= SSRS_CNT_RST;
      end else begin
         ok_q <= ok_d;
      end
   end

   a_supply_holds: assert property (
      @(posedge i_clk) disable iff (i_rst) sup_low |=> o_logic_reset)
      else $error("reset not held on low supply");
   a_wd_holds: assert property (
      @(posedge i_clk) disable iff (i_rst) clk_missing |=> o_logic_reset)
      else $error("reset not held on missing clock");
   a_delay_full: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $fell(o_logic_reset) |-> cnt_q == SSRS_CNT_W'(POR_CYCLES - 1))
      else $error("reset released before full delay");
   a_delay_count: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $fell(o_logic_reset) |-> ok_q == SSRS_CNT_W'(POR_CYCLES + 1))
      else $error("reset released without a full clean delay");
   a_ready_gate: assert property (
      @(posedge i_clk) disable iff (i_rst) o_spi_ready |-> !o_logic_reset)
      else $error("serial port ready during reset");
   a_flag_set: assert property (
      @(posedge i_clk) disable iff (i_rst)
      $fell(o_logic_reset) |-> o_reset_flag)
      else $error("reset flag not set on release");
   a_flag_clear: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (acc_ok(i_status_word_a_access, rdy_q) && !leaving) |=> !o_reset_flag)
      else $error("reset flag not cleared on access");
   for (genvar g = 0; g < SSRS_NCH; g++) begin : g_uv_chk
      a_uv_stage: assert property (
         @(posedge i_clk) disable iff (i_rst)
         (lsup_low[g] && st_d == SSRS_RUN) |=>
         (!o_stage_enable[g] && o_load_supply_undervoltage_flag[g]))
         else $error("channel not disabled on load undervoltage");
   end
   a_restart: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (st_q == SSRS_WAIT && hold_cond) |=>
      (st_q == SSRS_HOLD && cnt_q == SSRS_CNT_RST))
      else $error("delay not restarted");
   c_release: cover property (@(posedge i_clk) disable iff (i_rst)
      $fell(o_logic_reset));
   c_abort: cover property (@(posedge i_clk) disable iff (i_rst)
      st_q == SSRS_WAIT && hold_cond);
   c_access: cover property (@(posedge i_clk) disable iff (i_rst)
      o_reset_flag && i_status_word_a_access && rdy_q);
   c_clk_lost: cover property (@(posedge i_clk) disable iff (i_rst)
      clk_missing && !o_logic_reset);
endmodule // ssrs_top

/* tb/ssrs_mcu_model.sv */
// Purpose: microcontroller side, status_word_a word access requests
// Assumes: access strobe is a one-cycle pulse on the core clock
// Notes: holds back while the port is not ready, so early access is untested
`timescale 1ns/1ps
module ssrs_mcu_model (
   // Clock
   input wire logic i_clk,
   // Control
   input wire logic i_go,
   input wire logic i_spi_ready,
   // Request
   output logic o_access
);
   initial o_access = 1'b0;
   always @(negedge i_clk) begin
      o_access <= i_go && i_spi_ready && !o_access;
   end
endmodule // ssrs_mcu_model

/* tb/ssrs_top_tb.sv */
// Purpose: self-checking bench for the supply reset supervisor
// Assumes: short power-on delay parameter for simulation
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module ssrs_top_tb;
   import ssrs_pkg::*;
   localparam int unsigned POR = 8;
   logic clk, rst, wd, pls, run, go, acc;
   logic [2:0] sup, ll, pat;
   logic o_rst, o_rdy, o_flag;
   logic [2:0] o_uv, o_en;
   int miscompares, checks, cyc, n, seed;
   ssrs_top #(.POR_CYCLES(POR)) ssrs_top_inst (.i_clk(clk), .i_rst(rst),
      .i_digital_supply_low(sup[0]), .i_analog_supply_low(sup[1]),
      .i_reference_supply_low(sup[2]), .i_channel_load_supply_low(ll),
      .i_wd_enable(wd), .i_clk_pulse(pls), .i_status_word_a_access(acc),
      .o_logic_reset(o_rst), .o_spi_ready(o_rdy), .o_reset_flag(o_flag),
      .o_load_supply_undervoltage_flag(o_uv), .o_stage_enable(o_en));
   ssrs_mcu_model ssrs_mcu_model_inst (.i_clk(clk), .i_go(go),
      .i_spi_ready(o_rdy), .o_access(acc));
   always #12.5 clk = ~clk;
   always @(negedge clk) if (run) pls <= ~pls;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wt(input int k);
      repeat (k) @(negedge clk);
   endtask
   // Negedges from the last supply fix until the port is open:
   // two sync stages and the step into counting come before the delay
   function automatic int rel_wait(input int por);
      return por + 3;
   endfunction
   // Stage enables expected for a pattern of low load supplies
   function automatic logic [2:0] exp_stage(input logic [2:0] low);
      return ~low;
   endfunction
   // One status_word_a access; go moves by NBA so the model reads it cleanly
   task automatic diag_access();
      go <= 1'b1;
      wt(1);
      go <= 1'b0;
      wt(2);
   endtask
   // Cycles until the port becomes ready, bounded
   task automatic wait_rdy();
      n = 0;
      while (o_rdy !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      seed = 59432;
      clk = 0; rst = 1; wd = 0; pls = 0; run = 1; go = 0;
      sup = 3'h7; ll = 3'h0;
      wt(5);
      rst = 0;
      for (int i = 0; i < 6; i++) begin
         sup = (i < 3) ? 3'h1 << i : 3'($random(seed)) | 3'h1;
         wt(20);
         chk(o_rst, 3'h1);
      end
      $display("test supply hold done");
      sup = 3'h0;
      wt(rel_wait(POR) - 1);
      chk(o_rst, 3'h1);
      chk(o_rdy, 3'h0);
      wt(1);
      chk(o_rst, 3'h0);
      chk(o_rdy, 3'h1);
      chk(o_flag, 3'h1);
      diag_access();
      chk(o_flag, 3'h0);
      $display("test delay and flag done");
      for (int i = 0; i < 4; i++) begin
         pat = (i == 0) ? 3'h7 : 3'($random(seed)) | 3'h1;
         ll = pat;
         wt(6);
         chk(o_en, exp_stage(ll));
         chk(o_uv, pat);
         ll = 3'h0;
         wt(6);
         chk(o_en, 3'h7);
         chk(o_uv, pat);
         diag_access();
         chk(o_uv, 3'h0);
      end
      $display("test load supply done");
      sup = 3'h2;
      wt(6);
      chk(o_rst, 3'h1);
      sup = 3'h0;
      wt(POR - 3);
      sup = 3'h4;
      wt(3);
      sup = 3'h0;
      wt(rel_wait(POR) - 1);
      chk(o_rdy, 3'h0);
      wt(1);
      chk(o_rdy, 3'h1);
      chk(o_flag, 3'h1);
      diag_access();
      chk(o_flag, 3'h0);
      $display("test restart done");
      run = 0;
      wt(80);
      chk(o_rdy, 3'h1);
      run = 1;
      wt(5);
      wd = 1;
      wt(100);
      chk(o_rdy, 3'h1);
      run = 0;
      wt(80);
      chk(o_rst, 3'h1);
      run = 1;
      wt(20);
      wait_rdy();
      chk(o_rdy & o_flag, 3'h1);
      $display("test watchdog done");
      wrap_up();
   end
endmodule // ssrs_top_tb
